// [rtl/vpp_pixel_stream.sv]
// wide stream to 8-bit r,g,b symbol stream with frame start marker
// Notes on behaviour
// - 0:R:G:B mode splits each 64-bit beat into two pixels
// - fifo keeps display fed during stalls
// - drop top byte, keep 24-bit rgb
// - emit red, green, blue symbols in turn
// - frame start marker on first symbol
// - 5:6:5 pixels padded to 24 bits
// - 5:6:5 mode splits beat into four
`timescale 1ns/100ps
module vpp_pixel_stream (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        mode565,
  input  wire logic        padReplicate,
  input  wire logic [63:0] wideData,
  input  wire logic        wideStart,
  input  wire logic        wideValid,
  output logic             wideReady,
  output logic [7:0]       symData,
  output logic             symStart,
  output logic             symValid,
  input  wire logic        symReady
);
  // ---------------- width adapter ----------------
  logic [63:0] beat_reg;
  logic        beatStart_reg;
  logic        beatFull_reg;
  logic [1:0]  subIdx_reg;
  logic [31:0] subWord;
  logic        subStart;
  logic        subLast;
  logic        subTake;
  logic        fifoFull;
  // lowest sub-word first, ascending
  assign subWord = mode565 ?
    {16'h0000, beat_reg[subIdx_reg*vpp_pkg::HALF_W +: vpp_pkg::HALF_W]} :
    beat_reg[subIdx_reg[0]*vpp_pkg::PIX_W +: vpp_pkg::PIX_W];
  assign subStart = beatStart_reg && (subIdx_reg == 2'h0);
  assign subLast  = mode565 ? (subIdx_reg == vpp_pkg::LAST_HALF)
                            : subIdx_reg[0];
  assign subTake  = beatFull_reg && !fifoFull;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beatFull_reg  <= 1'b0;
      subIdx_reg    <= 2'h0;
      beat_reg      <= 64'h0;
      beatStart_reg <= 1'b0;
      wideReady     <= 1'b0;
    end else begin
      wideReady <= !(beatFull_reg && !(subTake && subLast)) && !wideReady
                   ? 1'b1 : wideReady && !(wideValid);
      if (wideValid && wideReady) begin
        beat_reg      <= wideData;
        beatStart_reg <= wideStart;
        beatFull_reg  <= 1'b1;
        subIdx_reg    <= 2'h0;
      end else if (subTake) begin
        subIdx_reg <= subIdx_reg + 2'h1;
        if (subLast) begin
          beatFull_reg <= 1'b0;
        end
      end
    end
  end

  // ---------------- slack fifo ----------------
  // memory stalls are absorbed here, not by the display side
  logic [32:0]  fifoMem [vpp_pkg::FIFO_DEPTH];
  logic [vpp_pkg::FIFO_AW:0] wrPtr_reg;
  logic [vpp_pkg::FIFO_AW:0] rdPtr_reg;
  logic         fifoEmpty;
  logic         fifoPop;
  logic [32:0]  fifoHead;
  assign fifoEmpty = (wrPtr_reg == rdPtr_reg);
  assign fifoFull  = (wrPtr_reg[vpp_pkg::FIFO_AW-1:0] ==
                      rdPtr_reg[vpp_pkg::FIFO_AW-1:0]) &&
                     (wrPtr_reg[vpp_pkg::FIFO_AW] !=
                      rdPtr_reg[vpp_pkg::FIFO_AW]);
  assign fifoHead  = fifoMem[rdPtr_reg[vpp_pkg::FIFO_AW-1:0]];

  always_ff @(posedge clk) begin
    if (subTake) begin
      fifoMem[wrPtr_reg[vpp_pkg::FIFO_AW-1:0]] <= {subStart, subWord};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (subTake) begin
        wrPtr_reg <= wrPtr_reg + 5'h01;
      end
      if (fifoPop) begin
        rdPtr_reg <= rdPtr_reg + 5'h01;
      end
    end
  end

  // ---------------- pixel converter ----------------
  logic [7:0]  redFull;
  logic [7:0]  grnFull;
  logic [7:0]  bluFull;
  logic [7:0]  red565;
  logic [7:0]  grn565;
  logic [7:0]  blu565;
  logic [23:0] rgb;
  logic [4:0]  r5;
  logic [5:0]  g6;
  logic [4:0]  b5;
  assign redFull = fifoHead[vpp_pkg::RED_LSB +: 8];
  assign grnFull = fifoHead[vpp_pkg::GRN_LSB +: 8];
  assign bluFull = fifoHead[vpp_pkg::BLU_LSB +: 8];
  assign r5 = fifoHead[vpp_pkg::R5_LSB +: 5];
  assign g6 = fifoHead[vpp_pkg::G6_LSB +: 6];
  assign b5 = fifoHead[vpp_pkg::B5_LSB +: 5];
  // replication copies each field's lsb into the pad bits
  assign red565 = {r5, padReplicate ? {3{r5[0]}} : 3'h0};
  assign grn565 = {g6, padReplicate ? {2{g6[0]}} : 2'h0};
  assign blu565 = {b5, padReplicate ? {3{b5[0]}} : 3'h0};
  assign rgb = mode565 ? {red565, grn565, blu565}
                       : {redFull, grnFull, bluFull};

  // ---------------- serializer ----------------
  vpp_pkg::vpp_sym_t sym_reg;
  vpp_pkg::vpp_sym_t sym_next;
  logic [23:0] pix_reg;
  logic        pixStart_reg;
  logic        symAdvance;
  logic        needPixel;
  assign symAdvance = !symValid || symReady;
  assign needPixel  = symAdvance && (sym_reg == vpp_pkg::VPP_SYM_RED);
  assign fifoPop    = needPixel && !fifoEmpty;

  always_comb begin
    sym_next = sym_reg;
    unique case (sym_reg)
      vpp_pkg::VPP_SYM_RED: begin
        if (fifoPop) begin
          sym_next = vpp_pkg::VPP_SYM_GRN;
        end
      end
      vpp_pkg::VPP_SYM_GRN: begin
        if (symAdvance) begin
          sym_next = vpp_pkg::VPP_SYM_BLU;
        end
      end
      vpp_pkg::VPP_SYM_BLU: begin
        if (symAdvance) begin
          sym_next = vpp_pkg::VPP_SYM_RED;
        end
      end
      default: begin
        sym_next = vpp_pkg::VPP_SYM_RED;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sym_reg      <= vpp_pkg::VPP_SYM_RED;
      pix_reg      <= 24'h000000;
      pixStart_reg <= 1'b0;
      symData      <= 8'h00;
      symStart     <= 1'b0;
      symValid     <= 1'b0;
    end else begin
      sym_reg <= sym_next;
      if (fifoPop) begin
        pix_reg      <= rgb;
        symData      <= rgb[23:16]; // red first
        symStart     <= fifoHead[32];
        symValid     <= 1'b1;
      end else if (symAdvance && sym_reg == vpp_pkg::VPP_SYM_GRN) begin
        symData  <= pix_reg[15:8];
        symStart <= 1'b0;
        symValid <= 1'b1;
      end else if (symAdvance && sym_reg == vpp_pkg::VPP_SYM_BLU) begin
        symData  <= pix_reg[7:0];
        symStart <= 1'b0;
        symValid <= 1'b1;
      end else if (symAdvance) begin
        symValid <= 1'b0;
        symStart <= 1'b0;
      end
    end
  end

  // ---------------- checks ----------------
  // a pixel popped and its red symbol taken by the sink
  sequence s_red_taken;
    fifoPop ##1 (symValid && symReady);
  endsequence

  a_sym_hold_stall: assert property (
    @(posedge clk) disable iff (!rst_n)
    symValid && !symReady |=> symValid && $stable(symData)
    && $stable(symStart))
    else $error("symbol changed while stalled");

  a_marker_only_red: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_red_taken ##1 (symValid && symReady) |-> !symStart)
    else $error("marker on a non-red symbol");

  a_three_symbols: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_red_taken |=> symValid && !symStart
    && sym_reg == vpp_pkg::VPP_SYM_BLU
    && symData == $past(rgb[15:8], 2))
    else $error("green symbol missing after red");

  a_fifo_no_overrun: assert property (
    @(posedge clk) disable iff (!rst_n)
    subTake |-> 5'(wrPtr_reg - rdPtr_reg) < 5'(vpp_pkg::FIFO_DEPTH))
    else $error("fifo written while full");

  a_split_order: assert property (
    @(posedge clk) disable iff (!rst_n)
    subTake && !subLast |=> subIdx_reg == $past(subIdx_reg) + 2'h1)
    else $error("sub-word order broken");

  a_red_value: assert property (
    @(posedge clk) disable iff (!rst_n)
    fifoPop && !mode565 |=> symData == $past(fifoHead[23:16]))
    else $error("red byte wrong");

  a_start_first_sub: assert property (
    @(posedge clk) disable iff (!rst_n)
    subTake && subIdx_reg != 2'h0 |-> !subStart)
    else $error("marker on later sub-word");

  a_pad_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    fifoPop && mode565 && !padReplicate |=> symData[2:0] == 3'h0)
    else $error("red pad not zero");
endmodule

// [rtl/vpp_pkg.sv]
// shared constants for the video pixel stream pipeline
package vpp_pkg;
  localparam int WIDE_W     = 64;
  localparam int PIX_W      = 32;
  localparam int HALF_W     = 16;
  localparam int RGB_W      = 24;
  localparam int SYM_W      = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  // byte positions inside a 0:R:G:B pixel
  localparam int RED_LSB    = 16;
  localparam int GRN_LSB    = 8;
  localparam int BLU_LSB    = 0;
  // field positions inside a 5:6:5 pixel
  localparam int R5_LSB     = 11;
  localparam int G6_LSB     = 5;
  localparam int B5_LSB     = 0;
  localparam logic [1:0] LAST_HALF = 2'h3;
  typedef enum logic [1:0] {
    VPP_SYM_RED = 2'b00,
    VPP_SYM_GRN = 2'b01,
    VPP_SYM_BLU = 2'b11
  } vpp_sym_t;
endpackage

// [verif/vpp_sink_model.sv]
// sink model for the r,g,b symbol stream, with optional stalling
`timescale 1ns/100ps
module vpp_sink_model #(
  parameter int LINE_PIX = 4
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] symData,
  input  wire logic       symStart,
  input  wire logic       symValid,
  input  wire logic       slow,
  output logic            symReady
);
  logic [8:0] got[$];
  logic [1:0] phase = 2'h0;
  int         pixInLine = 0;
  int         lineCnt = 0;
  int         markBad = 0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      symReady <= 1'b0;
    end else begin
      // alternate stalls push back through the fifo
      symReady <= slow ? ~symReady : 1'b1;
    end
  end
  // symbols kept in arrival order, three to a pixel
  // queue is emptied by the bench, so not an always_ff
  always @(posedge clk) begin
    if (rst_n && symValid && symReady) begin
      got.push_back({symStart, symData});
      if (symStart) begin
        // marker realigns timing; must land on a red slot
        markBad   <= markBad + int'(phase != 2'h0);
        phase     <= 2'h1;
        pixInLine <= 0;
        lineCnt   <= 0;
      end else begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        if (phase == 2'h2 && pixInLine == LINE_PIX - 1) begin
          pixInLine <= 0;
          lineCnt   <= lineCnt + 1;  // one line of timing
        end else if (phase == 2'h2) begin
          pixInLine <= pixInLine + 1;
        end
      end
    end
  end
endmodule

// [verif/testbench.sv]
// self-checking bench for the pixel stream pipeline
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        mode565 = 1'b0;
  logic        padReplicate = 1'b0;
  logic [63:0] wideData = 64'h0;
  logic        wideStart = 1'b0;
  logic        wideValid = 1'b0;
  logic        wideReady;
  logic [7:0]  symData;
  logic        symStart;
  logic        symValid;
  logic        symReady;
  logic        slow = 1'b0;
  logic [8:0]  expQ[$];
  int          numErrors = 0;
  int          nTests = 0;
  // short lines keep the frame small enough for a quick run
  localparam int LINE_PIX = 4;

  vpp_pixel_stream dut_u (.clk(clk), .rst_n(rst_n), .mode565(mode565),
    .padReplicate(padReplicate), .wideData(wideData),
    .wideStart(wideStart), .wideValid(wideValid), .wideReady(wideReady),
    .symData(symData), .symStart(symStart), .symValid(symValid),
    .symReady(symReady));
  vpp_sink_model #(.LINE_PIX(LINE_PIX)) sink_u (.clk(clk), .rst_n(rst_n),
    .symData(symData), .symStart(symStart), .symValid(symValid),
    .slow(slow), .symReady(symReady));

  initial forever #12.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %s exp %h got %h", what, exp, seen);
    end
  endtask

  task automatic expBeat(input logic [63:0] d, input logic s);
    logic [15:0] h;
    logic [23:0] p;
    for (int j = 0; j < (mode565 ? 4 : 2); j++) begin
      h = d[16*j +: 16];
      p = mode565 ? {h[15:11], padReplicate ? {3{h[11]}} : 3'h0,
                     h[10:5], padReplicate ? {2{h[5]}} : 2'h0,
                     h[4:0], padReplicate ? {3{h[0]}} : 3'h0}
                  : d[32*j +: 24];
      expQ.push_back({s && j == 0, p[23:16]});
      expQ.push_back({1'b0, p[15:8]});
      expQ.push_back({1'b0, p[7:0]});
    end
  endtask

  // beats offered back to back as one raster frame
  task automatic run(input int nb);
    logic [63:0] d;
    int k;
    @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      d = 64'hF1E2D3C4B5A69788 * 64'(i + 3);
      expBeat(d, i == 0);
      wideData <= d;
      wideStart <= (i == 0);
      wideValid <= 1'b1;
      @(negedge clk);
      for (k = 0; k < 200 && wideReady !== 1'b1; k++) @(negedge clk);
      check(32'(wideReady), 32'h1, "ready");
      @(posedge clk);
    end
    // released bus shows inverted data, not the last beat
    wideValid <= 1'b0;
    wideStart <= 1'b0;
    wideData <= ~d;
    for (k = 0; k < 800 && sink_u.got.size() < expQ.size(); k++)
      @(posedge clk);
    // let the sink's counters settle before looking
    @(negedge clk);
    check(32'(sink_u.got.size()), 32'(expQ.size()), "count");
    check(sink_u.lineCnt, expQ.size() / 3 / LINE_PIX, "lines");
    check(sink_u.markBad, 0, "align");
    foreach (expQ[n])
      check(32'(sink_u.got[n]), 32'(expQ[n]), "symbol");
    expQ.delete();
    sink_u.got.delete();
  endtask

  task automatic t_rgb32();
    @(posedge clk);
    mode565 <= 1'b0;
    slow <= 1'b1;
    run(8);
    $display("test rgb32 done");
  endtask

  task automatic t_565(input logic pad);
    @(posedge clk);
    mode565 <= 1'b1;
    padReplicate <= pad;
    slow <= 1'b0;
    run(3);
    $display("test 565 pad %0d done", pad);
  endtask

  task automatic completeRun();
    $display("checks %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_rgb32();
    t_565(1'b0);
    t_565(1'b1);
    completeRun();
  end

  initial begin
    #100000;
    numErrors++;
    completeRun();
  end
endmodule
